// ### voice_path_defs.vh
`ifndef VOICE_PATH_DEFS_VH
`define VOICE_PATH_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ADDR_TX_FIFO_IRQ_ENABLE 16'h2770
`define ADDR_RX_FIFO_IRQ_ENABLE 16'h2771
`define ADDR_DMA_IRQ_ENABLE 16'h2772
`define ADDR_TX_FIFO_IRQ_SOURCE 16'h2773
`define ADDR_RX_FIFO_IRQ_SOURCE 16'h2774
`define ADDR_DMA_IRQ_SOURCE 16'h2775
`define ADDR_INTERFACE_SELECT 16'h277a
`define ADDR_MUTE_BYTE_HIGH 16'h277c
`define ADDR_MUTE_BYTE_LOW 16'h277d
`define ADDR_PATH_WIDTH_MUTE_CONTROL 16'h277e
`define ADDR_FIFO_MAPPING_SELECT 16'h277f

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_FIFO_EMPTY 7
`define BIT_FIFO_FULL 6
`define BIT_TX_DMA_DONE 4
`define BIT_RX_DMA_DONE 0
`define FIFO_IRQ_MASK 8'h00c0
`define DMA_IRQ_MASK 8'h0011
`define IFSEL_HI 6
`define IFSEL_LO 5
`define IFSEL_MASK 8'h0060
`define BIT_DECODER_SIDE_MUTE 6
`define BIT_DECODER_SPLIT_INIT 5
`define BIT_DECODER_WORD_SPLIT 4
`define BIT_ENCODER_SIDE_MUTE 2
`define BIT_ENCODER_JOIN_INIT 1
`define BIT_ENCODER_WORD_JOIN 0
`define PATH_CTL_MASK 8'h0077
`define FIFO_MAP_MASK 8'h0007

// ------------------------------------------------------------
// encodings and reset values
// ------------------------------------------------------------
`define IFSEL_I2S 2'h0
`define IFSEL_SPI 2'h1
`define IFSEL_FIRST_UART 2'h2
`define IFSEL_SECOND_UART 2'h3
`define MAP_DEDICATED 3'h0
`define MAP_FIRST_UART 3'h1
`define MAP_SECOND_UART 3'h2
`define MAP_SPI 3'h3
`define MAP_DATA_MEMORY 3'h7
`define DATA_MEM_BASE 16'h1a00
`define DATA_MEM_LIMIT 16'h1bff
`define VOICE_FIFO_DEPTH 9'h0100
`define REG_RESET 8'h00

`endif

// ### voice_path_control.v
// Notes on behaviour
// - tx fifo enable: empty enable bit 7, full enable bit 6, reset zero.
// - rx fifo enable: empty bit 7, full bit 6, read/write, reset zero.
// - dma enable: tx done bit 4, rx done bit 0, others zero.
// - tx empty flag sets when enabled and condition high; software clears it.
// - tx source: full event bit 6, bits 5:0 read zero.
// - rx source: empty bit 7, full bit 6, reset zero.
// - dma source: tx done bit 4, rx done bit 0, others zero.
// - interface select bits 6:5: i2s, spi, first uart, second uart.
// - decoder mute sends the two mute bytes outward instead of decoder data, only the low byte without split.
// - decoder split init bit 5 resets the word splitter.
// - split mode sends decoder words as upper byte then lower byte.
// - encoder mute feeds the two mute bytes to the encoder.
// - encoder join init bit 1 resets the byte joiner.
// - join mode pairs bytes, first received byte upper half.
// - mapping 0 dedicated fifos, 1 first uart, 2 second uart, 3 spi.
// - mapping 7 puts voice fifo storage in data memory window.
// - dedicated tx and rx fifos each hold 256 bytes.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "voice_path_defs.vh"

module voice_path_control (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// register port
	input wire [15:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// fifo and dma events
	input wire tx_fifo_condition_value_i,
	input wire tx_fifo_full_i,
	input wire rx_fifo_empty_i,
	input wire rx_fifo_full_i,
	input wire tx_dma_complete_i,
	input wire rx_dma_complete_i,
	output wire irq_o,
	// external bytes in, one lane per interface
	input wire [31:0] ext_rx_data_i,
	input wire [3:0] ext_rx_valid_i,
	// encoder side
	output reg [15:0] enc_word_o,
	output reg enc_valid_o,
	// decoder side
	input wire [15:0] dec_word_i,
	input wire dec_valid_i,
	output wire dec_ready_o,
	// external bytes out
	output reg [7:0] ext_tx_data_o,
	output reg [3:0] ext_tx_valid_o,
	// fifo mapping
	output wire [2:0] fifo_map_o,
	output wire map_dedicated_o,
	output wire map_data_memory_o,
	output wire [15:0] data_mem_base_o,
	output wire [15:0] data_mem_limit_o,
	output wire [8:0] fifo_depth_o
);

// ------------------------------------------------------------
// register state
// ------------------------------------------------------------
// software registers, reserved bits held at zero
reg [7:0] tx_fifo_irq_enable;
reg [7:0] rx_fifo_irq_enable;
reg [7:0] dma_irq_enable;
reg [7:0] tx_fifo_irq_source;
reg [7:0] rx_fifo_irq_source;
reg [7:0] dma_irq_source;
reg [7:0] interface_select;
reg [7:0] mute_byte_high;
reg [7:0] mute_byte_low;
reg [7:0] path_width_mute_control;
reg [7:0] fifo_mapping_select;
reg [7:0] next_rdata;

// decode a write to one offset
function wr_hit;
	input [15:0] a;
	input [15:0] off;
	input w;
	begin
		wr_hit = w && (a == off);
	end
endfunction

// sticky flag: event sets, written zero clears, set wins
// an event and a clear in one cycle keep the flag set
function [7:0] sticky;
	input [7:0] cur;
	input [7:0] evt;
	input [7:0] wval;
	input w;
	input [7:0] mask;
	begin
		if (w) begin
			// written zeros clear, written ones keep
			sticky = ((cur & wval) | evt) & mask;
		end else begin
			// no write, only events can set
			sticky = (cur | evt) & mask;
		end
	end
endfunction

// one write hit per offset
wire w_txe = wr_hit(addr_i, `ADDR_TX_FIFO_IRQ_ENABLE, wr_i);
wire w_rxe = wr_hit(addr_i, `ADDR_RX_FIFO_IRQ_ENABLE, wr_i);
wire w_dme = wr_hit(addr_i, `ADDR_DMA_IRQ_ENABLE, wr_i);
wire w_txs = wr_hit(addr_i, `ADDR_TX_FIFO_IRQ_SOURCE, wr_i);
wire w_rxs = wr_hit(addr_i, `ADDR_RX_FIFO_IRQ_SOURCE, wr_i);
wire w_dms = wr_hit(addr_i, `ADDR_DMA_IRQ_SOURCE, wr_i);
wire w_ifs = wr_hit(addr_i, `ADDR_INTERFACE_SELECT, wr_i);
wire w_mhi = wr_hit(addr_i, `ADDR_MUTE_BYTE_HIGH, wr_i);
wire w_mlo = wr_hit(addr_i, `ADDR_MUTE_BYTE_LOW, wr_i);
wire w_pct = wr_hit(addr_i, `ADDR_PATH_WIDTH_MUTE_CONTROL, wr_i);
wire w_map = wr_hit(addr_i, `ADDR_FIFO_MAPPING_SELECT, wr_i);

// ------------------------------------------------------------
// event vectors
// ------------------------------------------------------------
// each event gated by its enable before the flag
wire [7:0] tx_evt;
wire [7:0] rx_evt;
wire [7:0] dma_evt;

assign tx_evt[`BIT_FIFO_EMPTY] = tx_fifo_irq_enable[`BIT_FIFO_EMPTY] & tx_fifo_condition_value_i;
assign tx_evt[`BIT_FIFO_FULL] = tx_fifo_irq_enable[`BIT_FIFO_FULL] & tx_fifo_full_i;
assign tx_evt[5:0] = 6'h00;
assign rx_evt[`BIT_FIFO_EMPTY] = rx_fifo_irq_enable[`BIT_FIFO_EMPTY] & rx_fifo_empty_i;
assign rx_evt[`BIT_FIFO_FULL] = rx_fifo_irq_enable[`BIT_FIFO_FULL] & rx_fifo_full_i;
assign rx_evt[5:0] = 6'h00;
assign dma_evt[7:5] = 3'h0;
assign dma_evt[`BIT_TX_DMA_DONE] = dma_irq_enable[`BIT_TX_DMA_DONE] & tx_dma_complete_i;
assign dma_evt[3:1] = 3'h0;
assign dma_evt[`BIT_RX_DMA_DONE] = dma_irq_enable[`BIT_RX_DMA_DONE] & rx_dma_complete_i;

// ------------------------------------------------------------
// register writes and flags
// ------------------------------------------------------------
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		tx_fifo_irq_enable <= `REG_RESET;
		rx_fifo_irq_enable <= `REG_RESET;
		dma_irq_enable <= `REG_RESET;
		tx_fifo_irq_source <= `REG_RESET;
		rx_fifo_irq_source <= `REG_RESET;
		dma_irq_source <= `REG_RESET;
		interface_select <= `REG_RESET;
		mute_byte_high <= `REG_RESET;
		mute_byte_low <= `REG_RESET;
		path_width_mute_control <= `REG_RESET;
		fifo_mapping_select <= `REG_RESET;
	end else begin
		if (w_txe) begin
			tx_fifo_irq_enable <= wdata_i & `FIFO_IRQ_MASK;
		end
		if (w_rxe) begin
			rx_fifo_irq_enable <= wdata_i & `FIFO_IRQ_MASK;
		end
		if (w_dme) begin
			dma_irq_enable <= wdata_i & `DMA_IRQ_MASK;
		end
		tx_fifo_irq_source <= sticky(tx_fifo_irq_source, tx_evt, wdata_i, w_txs,
			`FIFO_IRQ_MASK);
		rx_fifo_irq_source <= sticky(rx_fifo_irq_source, rx_evt, wdata_i, w_rxs,
			`FIFO_IRQ_MASK);
		dma_irq_source <= sticky(dma_irq_source, dma_evt, wdata_i, w_dms, `DMA_IRQ_MASK);
		if (w_ifs) begin
			interface_select <= wdata_i & `IFSEL_MASK;
		end
		// mute byte pair, shared by both paths
		if (w_mhi) begin
			mute_byte_high <= wdata_i;
		end
		if (w_mlo) begin
			mute_byte_low <= wdata_i;
		end
		// path control, reserved bits 7 and 3 dropped
		if (w_pct) begin
			path_width_mute_control <= wdata_i & `PATH_CTL_MASK;
		end
		if (w_map) begin
			fifo_mapping_select <= wdata_i & `FIFO_MAP_MASK;
		end
	end
end

// ------------------------------------------------------------
// read path, data one cycle after the strobe
// ------------------------------------------------------------
// read mux, unmapped offsets give zero
always @* begin
	next_rdata = 8'h00;
	if (rd_i) begin
		case (addr_i)
			`ADDR_TX_FIFO_IRQ_ENABLE: next_rdata = tx_fifo_irq_enable;
			`ADDR_RX_FIFO_IRQ_ENABLE: next_rdata = rx_fifo_irq_enable;
			`ADDR_DMA_IRQ_ENABLE: next_rdata = dma_irq_enable;
			`ADDR_TX_FIFO_IRQ_SOURCE: next_rdata = tx_fifo_irq_source;
			`ADDR_RX_FIFO_IRQ_SOURCE: next_rdata = rx_fifo_irq_source;
			`ADDR_DMA_IRQ_SOURCE: next_rdata = dma_irq_source;
			`ADDR_INTERFACE_SELECT: next_rdata = interface_select;
			`ADDR_MUTE_BYTE_HIGH: next_rdata = mute_byte_high;
			`ADDR_MUTE_BYTE_LOW: next_rdata = mute_byte_low;
			`ADDR_PATH_WIDTH_MUTE_CONTROL: next_rdata = path_width_mute_control;
			`ADDR_FIFO_MAPPING_SELECT: next_rdata = fifo_mapping_select;
			default: next_rdata = 8'h00;
		endcase
	end
end

// read data register, zero when no read
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		rdata_o <= 8'h00;
	end else begin
		rdata_o <= next_rdata;
	end
end

// ------------------------------------------------------------
// interrupt request
// ------------------------------------------------------------
// pending sources, flag and enable both set
wire [7:0] tx_pend = tx_fifo_irq_source & tx_fifo_irq_enable;
wire [7:0] rx_pend = rx_fifo_irq_source & rx_fifo_irq_enable;
wire [7:0] dma_pend = dma_irq_source & dma_irq_enable;

// level output, drops once the last pending flag clears
// any enabled flag raises request
assign irq_o = |(tx_pend | rx_pend | dma_pend);

// ------------------------------------------------------------
// encoder side: select, join, mute
// ------------------------------------------------------------
// control fields decoded once for both paths
wire [1:0] if_sel = interface_select[`IFSEL_HI:`IFSEL_LO];
wire enc_mute = path_width_mute_control[`BIT_ENCODER_SIDE_MUTE];
wire enc_init = path_width_mute_control[`BIT_ENCODER_JOIN_INIT];
wire enc_join = path_width_mute_control[`BIT_ENCODER_WORD_JOIN];
wire dec_mute = path_width_mute_control[`BIT_DECODER_SIDE_MUTE];
wire dec_init = path_width_mute_control[`BIT_DECODER_SPLIT_INIT];
wire dec_split = path_width_mute_control[`BIT_DECODER_WORD_SPLIT];
// mute pair as one word, high byte first
wire [15:0] mute_word = {mute_byte_high, mute_byte_low};

wire [7:0] in_byte = ext_rx_data_i[{if_sel, 3'h0} +: 8];
wire in_valid = ext_rx_valid_i[if_sel];

// joiner phase and saved upper byte
reg join_half;
reg [7:0] join_high;

// encoder word builder, other lanes ignored
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		join_half <= 1'b0;
		join_high <= 8'h00;
		enc_word_o <= 16'h0000;
		enc_valid_o <= 1'b0;
	end else begin
		// word strobe lasts one cycle
		enc_valid_o <= 1'b0;
		// a byte seen while init is set is dropped
		// joiner held in init
		if (enc_init) begin
			join_half <= 1'b0;
			join_high <= 8'h00;
		end else if (in_valid) begin
			if (enc_join) begin
				if (!join_half) begin
					join_high <= in_byte;
					join_half <= 1'b1;
				end else begin
					join_half <= 1'b0;
					enc_valid_o <= 1'b1;
					enc_word_o <= enc_mute ? mute_word : {join_high, in_byte};
				end
			end else begin
				// plain mode, one byte makes one word
				join_half <= 1'b0;
				enc_valid_o <= 1'b1;
				enc_word_o <= enc_mute ? mute_word : {8'h00, in_byte};
			end
		end
	end
end

// ------------------------------------------------------------
// decoder side: mute, split, route out
// ------------------------------------------------------------
// low byte waits one cycle in split mode
reg split_pending;
reg [7:0] split_low;

// accept a new word only when no low byte waits
assign dec_ready_o = !split_pending && !dec_init;

// decoder byte sender, one byte per cycle
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		split_pending <= 1'b0;
		split_low <= 8'h00;
		ext_tx_data_o <= 8'h00;
		ext_tx_valid_o <= 4'h0;
	end else begin
		// lane pulses last one cycle
		ext_tx_valid_o <= 4'h0;
		if (dec_init) begin
			split_pending <= 1'b0;
			split_low <= 8'h00;
		end else if (split_pending) begin
			split_pending <= 1'b0;
			ext_tx_data_o <= split_low;
			ext_tx_valid_o <= 4'h1 << if_sel;
		end else if (dec_valid_i) begin
			// word taken, valid with ready high
			ext_tx_valid_o <= 4'h1 << if_sel;
			if (dec_split) begin
				ext_tx_data_o <= dec_mute ? mute_byte_high : dec_word_i[15:8];
				split_low <= dec_mute ? mute_byte_low : dec_word_i[7:0];
				split_pending <= 1'b1;
			end else begin
				ext_tx_data_o <= dec_mute ? mute_byte_low : dec_word_i[7:0];
			end
		end
	end
end

// ------------------------------------------------------------
// fifo mapping
// ------------------------------------------------------------
// only the field is stored
assign fifo_map_o = fifo_mapping_select[2:0];
assign map_dedicated_o = (fifo_map_o == `MAP_DEDICATED);
assign map_data_memory_o = (fifo_map_o == `MAP_DATA_MEMORY);
// window bounds and depth reported as constants
assign data_mem_base_o = `DATA_MEM_BASE;
assign data_mem_limit_o = `DATA_MEM_LIMIT;
assign fifo_depth_o = `VOICE_FIFO_DEPTH;

endmodule // voice_path_control

`default_nettype wire

// ### voice_path_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module voice_path_chk (
	// clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// register port
	input wire [15:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	input wire irq_o,
	// data paths
	input wire [3:0] ext_rx_valid_i,
	input wire enc_valid_o,
	input wire dec_valid_i,
	input wire dec_ready_o,
	input wire [3:0] ext_tx_valid_o,
	// mapping
	input wire [2:0] fifo_map_o,
	input wire map_dedicated_o,
	input wire map_data_memory_o,
	input wire [15:0] data_mem_base_o,
	input wire [15:0] data_mem_limit_o,
	input wire [8:0] fifo_depth_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_tx_src_rsv;
		$past(rd_i) && $past(addr_i) == 16'h2773 |-> rdata_o[5:0] == 6'h00;
	endproperty
	a_tx_src_rsv: assert property (p_tx_src_rsv) else $error("tx source low bits set");
	property p_dma_src_rsv;
		$past(rd_i) && $past(addr_i) == 16'h2775 |-> (rdata_o & 8'hee) == 8'h00;
	endproperty
	a_dma_src_rsv: assert property (p_dma_src_rsv) else $error("dma source spare bits set");
	property p_irq_fall;
		$fell(irq_o) |-> $past(wr_i);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped with no write");
	property p_enc_cause;
		enc_valid_o |-> $past(|ext_rx_valid_i);
	endproperty
	a_enc_cause: assert property (p_enc_cause) else $error("encoder word with no byte");
	property p_tx_lane;
		$onehot0(ext_tx_valid_o);
	endproperty
	a_tx_lane: assert property (p_tx_lane) else $error("several lanes driven");
	property p_tx_cause;
		|ext_tx_valid_o |-> $past(dec_valid_i && dec_ready_o) || $past(!dec_ready_o);
	endproperty
	a_tx_cause: assert property (p_tx_cause) else $error("byte out with no word");
	property p_map_write;
		$changed(fifo_map_o) |-> $past(wr_i) && $past(addr_i) == 16'h277f;
	endproperty
	a_map_write: assert property (p_map_write) else $error("mapping moved unasked");
	property p_map_decode;
		map_dedicated_o == (fifo_map_o == 3'h0) && map_data_memory_o == (fifo_map_o == 3'h7);
	endproperty
	a_map_decode: assert property (p_map_decode) else $error("mapping decode wrong");
	property p_window;
		data_mem_base_o == 16'h1a00 && data_mem_limit_o == 16'h1bff && fifo_depth_o == 9'h100;
	endproperty
	a_window: assert property (p_window) else $error("window or depth wrong");
	// main scenarios reached
	c_irq: cover property ($rose(irq_o));
	c_enc: cover property (enc_valid_o);
	c_tx: cover property (|ext_tx_valid_o);
endmodule // voice_path_chk
bind voice_path_control voice_path_chk u_chk (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .irq_o(irq_o), .ext_rx_valid_i(ext_rx_valid_i),
	.enc_valid_o(enc_valid_o), .dec_valid_i(dec_valid_i), .dec_ready_o(dec_ready_o),
	.ext_tx_valid_o(ext_tx_valid_o), .fifo_map_o(fifo_map_o),
	.map_dedicated_o(map_dedicated_o), .map_data_memory_o(map_data_memory_o),
	.data_mem_base_o(data_mem_base_o), .data_mem_limit_o(data_mem_limit_o),
	.fifo_depth_o(fifo_depth_o));
`default_nettype wire

// ### voice_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module voice_far_side (
	// clock
	input wire logic clock_i,
	// bytes toward the block
	output logic [31:0] rx_data_o,
	output logic [3:0] rx_valid_o,
	// bytes from the block
	input wire logic [7:0] tx_data_i,
	input wire logic [3:0] tx_valid_i
);
	logic [11:0] got [$];
	initial begin
		rx_data_o = 32'h0000_0000;
		rx_valid_o = 4'h0;
	end
	// one byte on one lane, lines scrambled once released
	task send(input [1:0] lane, input [7:0] b);
		@(posedge clock_i);
		rx_valid_o <= 4'h1 << lane;
		rx_data_o[lane*8 +: 8] <= b;
		@(posedge clock_i);
		rx_valid_o <= 4'h0;
		rx_data_o <= ~rx_data_o;
	endtask
	// record every byte sent outward with its lane
	always @(posedge clock_i) begin
		if (|tx_valid_i)
			got.push_back({tx_valid_i, tx_data_i});
	end
endmodule // voice_far_side
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ------------------------------------------------------------
	// stimulus and wiring
	// ------------------------------------------------------------
	logic clock_i = 0;
	logic rst_n_i = 0;
	logic [15:0] addr_i = 0;
	logic [7:0] wdata_i = 0;
	logic wr_i = 0;
	logic rd_i = 0;
	logic [5:0] ev = 0;
	logic [15:0] dec_word_i = 0;
	logic dec_valid_i = 0;
	wire [7:0] rdata_o;
	wire [7:0] ext_tx_data_o;
	wire [3:0] ext_tx_valid_o;
	wire [31:0] ext_rx_data_i;
	wire [3:0] ext_rx_valid_i;
	wire [15:0] enc_word_o;
	wire [2:0] fifo_map_o;
	wire irq_o;
	wire enc_valid_o;
	wire dec_ready_o;
	wire map_dedicated_o;
	wire map_data_memory_o;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	int i;
	int e;
	logic [2:0] lane;
	logic [15:0] enc_q [$];
	logic [15:0] ra [9] = '{16'h2770, 16'h2771, 16'h2772, 16'h2773, 16'h2774,
		16'h2775, 16'h277a, 16'h277e, 16'h277f};
	logic [7:0] rm [9] = '{8'hc0, 8'hc0, 8'h11, 8'h00, 8'h00, 8'h00, 8'h60, 8'h77, 8'h07};
	logic [7:0] sb [6] = '{8'h80, 8'h40, 8'h80, 8'h40, 8'h10, 8'h01};
	always #5 clock_i = ~clock_i;
	voice_path_control DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.tx_fifo_condition_value_i(ev[0]), .tx_fifo_full_i(ev[1]),
		.rx_fifo_empty_i(ev[2]), .rx_fifo_full_i(ev[3]), .tx_dma_complete_i(ev[4]),
		.rx_dma_complete_i(ev[5]), .irq_o(irq_o), .ext_rx_data_i(ext_rx_data_i),
		.ext_rx_valid_i(ext_rx_valid_i), .enc_word_o(enc_word_o),
		.enc_valid_o(enc_valid_o), .dec_word_i(dec_word_i), .dec_valid_i(dec_valid_i),
		.dec_ready_o(dec_ready_o), .ext_tx_data_o(ext_tx_data_o),
		.ext_tx_valid_o(ext_tx_valid_o), .fifo_map_o(fifo_map_o),
		.map_dedicated_o(map_dedicated_o), .map_data_memory_o(map_data_memory_o),
		.data_mem_base_o(), .data_mem_limit_o(), .fifo_depth_o());
	voice_far_side far (.clock_i(clock_i), .rx_data_o(ext_rx_data_i),
		.rx_valid_o(ext_rx_valid_i), .tx_data_i(ext_tx_data_o), .tx_valid_i(ext_tx_valid_o));
	// ------------------------------------------------------------
	// access and compare tasks
	// ------------------------------------------------------------
	task check(input string what, input [15:0] got, input [15:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task wr(input [15:0] a, input [7:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1;
		@(posedge clock_i);
		wr_i <= 0;
	endtask
	task rdc(input [15:0] a, input [7:0] exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge clock_i);
		rd_i <= 0;
		#1 check("rdata", rdata_o, exp);
	endtask
	task dec(input [15:0] w);
		@(posedge clock_i);
		dec_word_i <= w;
		dec_valid_i <= 1;
		#1 while (dec_ready_o !== 1'b1) @(posedge clock_i) #1;
		@(posedge clock_i);
		dec_valid_i <= 0;
		dec_word_i <= ~w;
	endtask
	task exp_tx(input [11:0] x);
		check("ext_tx", far.got.size() ? far.got.pop_front() : 12'hfff, x);
	endtask
	task exp_enc(input [15:0] x);
		check("enc_word", enc_q.size() ? enc_q.pop_front() : 16'hxxxx, x);
	endtask
	task close_out;
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// capture encoder words, cut a hang short
	always @(posedge clock_i) begin
		if (enc_valid_o === 1'b1)
			enc_q.push_back(enc_word_o);
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			close_out;
		end
	end
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clock_i);
		rst_n_i <= 1;
		for (i = 0; i < 9; i++) begin
			rdc(ra[i], 8'h00);
			wr(ra[i], 8'hff);
			rdc(ra[i], rm[i]);
		end
		for (i = 0; i < 8; i++) begin
			wr(16'h277f, i[7:0]);
			#1 check("map", {map_dedicated_o, map_data_memory_o, fifo_map_o}, {i == 0, i == 7, i[2:0]});
		end
		wr(16'h2776, 8'hff);
		rdc(16'h2776, 8'h00);
		for (i = 0; i < 9; i++) wr(ra[i], 8'h00);
		// events with enables off, then on
		for (e = 0; e < 2; e++) begin
			for (i = 0; i < 3; i++) wr(ra[i], e ? rm[i] : 8'h00);
			for (i = 0; i < 6; i++) begin
				@(posedge clock_i) ev <= 6'h01 << i;
				@(posedge clock_i) ev <= 6'h00;
				repeat (3) @(posedge clock_i);
				#1 check("irq", irq_o, e);
				wr(16'h2773 + i / 2, 8'hff);
				rdc(16'h2773 + i / 2, e ? sb[i] : 8'h00);
				wr(16'h2773 + i / 2, 8'h00);
				#1 check("irq", irq_o, 0);
			end
		end
		// both paths per lane, mute on odd lanes
		wr(16'h277c, 8'h5a);
		wr(16'h277d, 8'ha5);
		for (lane = 0; lane < 4; lane++) begin
			wr(16'h277a, {1'b0, lane[1:0], 5'h00});
			wr(16'h277e, lane[0] ? 8'h55 : 8'h11);
			far.send(lane[1:0], 8'ha0 + lane);
			far.send(lane[1:0] + 2'h1, 8'h55);
			far.send(lane[1:0], 8'h3c);
			repeat (3) @(posedge clock_i);
			exp_enc(lane[0] ? 16'h5aa5 : {8'ha0 + lane, 8'h3c});
			dec({8'h12 + lane, 8'h34 + lane});
			repeat (4) @(posedge clock_i);
			exp_tx({4'h1 << lane, lane[0] ? 8'h5a : 8'h12 + lane});
			exp_tx({4'h1 << lane, lane[0] ? 8'ha5 : 8'h34 + lane});
		end
		// joiner init drops a stray byte, plain width modes
		wr(16'h277a, 8'h00);
		wr(16'h277e, 8'h03);
		far.send(2'h0, 8'h99);
		wr(16'h277e, 8'h01);
		far.send(2'h0, 8'h11);
		far.send(2'h0, 8'h22);
		repeat (3) @(posedge clock_i);
		exp_enc(16'h1122);
		wr(16'h277e, 8'h00);
		far.send(2'h0, 8'h77);
		dec(16'h4321);
		repeat (4) @(posedge clock_i);
		exp_enc(16'h0077);
		exp_tx({4'h1, 8'h21});
		// mute with plain width on both paths
		wr(16'h277e, 8'h44);
		far.send(2'h0, 8'h66);
		dec(16'h8765);
		repeat (4) @(posedge clock_i);
		exp_enc(16'h5aa5);
		exp_tx({4'h1, 8'ha5});
		check("leftover", enc_q.size() + far.got.size(), 0);
		wr(16'h277e, 8'h30);
		#1 check("dec_ready", dec_ready_o, 0);
		close_out;
	end
endmodule // testbench
`default_nettype wire
